// >>> core/plbk_core.sv
// Purpose: Loopback steering between MAC and line byte streams
// Assumes: Link data and MAC data share LINK_CLK; frames start at DA
// Notes: Config crosses to LINK_CLK, applied once two samples agree
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module plbk_core
   import plbk_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic AN_GIG_FD,
   input wire logic LINK_CLK,
   input wire plbk_byte_t MAC_TX,
   output plbk_byte_t MAC_RX,
   input wire plbk_byte_t LINE_RX,
   output plbk_byte_t LINE_TX
);
   if (ADDR_W < 8) begin : g_bad_addr_w
      $error("ADDR_W below 8 cannot decode the register map");
   end

   logic [15:0] basic_q, ms_q, pcs_q, common_q, ext_q;
   logic [15:0] frames_q;
   logic [31:0] prdata_q, rd_mux;
   logic rd_ok_q, xfer, wr, hit;
   logic an_s1_q, an_s2_q;
   logic tgl_s1_q, tgl_s2_q, tgl_s3_q, done_tgl_q;
   logic forced_gig, duplex_ok, slave_ok, ext_gig_ok;
   plbk_mode_t lb_mode, mode_sys_q;

   // Bus handshake
   assign xfer = PSEL && PENABLE && rd_ok_q;
   assign wr = xfer && PWRITE && CE;
   assign PREADY = CE && rd_ok_q;
   assign PRDATA = prdata_q;

   always_comb begin
      hit = 1'b1;
      rd_mux = 32'h00000000;
      unique case (PADDR[7:0])
         ADDR_BASIC: rd_mux = {16'h0000, basic_q};
         ADDR_MS: rd_mux = {16'h0000, ms_q};
         ADDR_PCS_LB: rd_mux = {16'h0000, pcs_q};
         ADDR_COMMON: rd_mux = {16'h0000, common_q};
         ADDR_EXT_LB: rd_mux = {16'h0000, ext_q};
         ADDR_STATUS: rd_mux = {26'h0000000, lb_mode.speed, lb_mode.ext_en,
            lb_mode.swap_en, lb_mode.remote_en, lb_mode.local_en};
         ADDR_FRAMES: rd_mux = {16'h0000, frames_q};
         default: hit = 1'b0;
      endcase
   end
   assign PSLVERR = xfer && CE && !hit;

   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         rd_ok_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else if (CE) begin
         rd_ok_q <= PSEL && !xfer;
         if (PSEL && !rd_ok_q) begin
            prdata_q <= rd_mux;
         end
      end
   end

   // Register writes
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         basic_q <= BASIC_RST;
         ms_q <= REG_ZERO_RST;
         pcs_q <= REG_ZERO_RST;
         common_q <= REG_ZERO_RST;
         ext_q <= REG_ZERO_RST;
      end else if (wr && hit) begin
         unique case (PADDR[7:0])
            ADDR_BASIC: basic_q <= PWDATA[15:0];
            ADDR_MS: ms_q <= PWDATA[15:0];
            ADDR_PCS_LB: pcs_q <= PWDATA[15:0];
            ADDR_COMMON: common_q <= PWDATA[15:0];
            ADDR_EXT_LB: ext_q <= PWDATA[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         an_s1_q <= 1'b0;
         an_s2_q <= 1'b0;
         mode_sys_q <= '0;
      end else if (CE) begin
         an_s1_q <= AN_GIG_FD;
         an_s2_q <= an_s1_q;
         mode_sys_q <= lb_mode;
      end
   end

   // Mode decode
   always_comb begin
      lb_mode.speed = {basic_q[BC_SPD_LSB], basic_q[BC_SPD_MSB]};
      duplex_ok = !basic_q[BC_AN_EN] && basic_q[BC_DUPLEX];
      slave_ok = ms_q[MS_MANUAL] && !ms_q[MS_VALUE];
      forced_gig = duplex_ok && (lb_mode.speed == SPD_1000);
      ext_gig_ok = (basic_q == EXT_GIG_BASIC) && ms_q[MS_MANUAL]
         && ms_q[MS_VALUE];
      lb_mode.local_en = basic_q[BC_LOOP] && duplex_ok
         && ((lb_mode.speed == SPD_10) || (lb_mode.speed == SPD_100)
         || (lb_mode.speed == SPD_1000 && slave_ok));
      lb_mode.remote_en = pcs_q[PCS_REMOTE] && !lb_mode.local_en
         && (forced_gig || (basic_q[BC_AN_EN] && an_s2_q));
      lb_mode.swap_en = lb_mode.remote_en && common_q[CC_SWITCH_LB];
      lb_mode.ext_en = ext_q[EXT_LB_BIT] && !lb_mode.local_en
         && !lb_mode.remote_en
         && ((lb_mode.speed != SPD_1000) || ext_gig_ok);
   end

   // Looped frame count, toggle from link side
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_s3_q <= 1'b0;
         frames_q <= 16'h0000;
      end else if (CE) begin
         tgl_s1_q <= done_tgl_q;
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= tgl_s2_q;
         if (tgl_s2_q != tgl_s3_q) begin
            frames_q <= frames_q + 16'h0001;
         end
      end
   end

   // Link clock domain
   plbk_mode_t mode_s1_q, mode_s2_q, mode_sync_q, mode_prev_q;
   logic ce_s1_q, lce;
   plbk_byte_t pipe_q [PIPE_LEN];
   logic [7:0] hdr_q [PIPE_LEN];
   logic [3:0] in_cnt_q, out_cnt_q, hdr_idx;
   logic [1:0] crc_idx_q;
   logic [31:0] crc_q;
   logic tail, frame_end;
   logic [7:0] sw_data;
   plbk_byte_t out_b, loop_b;

   function automatic logic [31:0] crc_byte(input logic [31:0] c,
      input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   always_ff @(posedge LINK_CLK or posedge RESET) begin
      if (RESET) begin
         mode_s1_q <= '0;
         mode_s2_q <= '0;
         mode_sync_q <= '0;
         mode_prev_q <= '0;
         ce_s1_q <= 1'b0;
         lce <= 1'b0;
      end else begin
         mode_s1_q <= mode_sys_q;
         mode_sync_q <= mode_s1_q;
         mode_prev_q <= mode_sync_q;
         if (lce && mode_sync_q == mode_prev_q) begin
            mode_s2_q <= mode_sync_q;
         end
         ce_s1_q <= CE;
         lce <= ce_s1_q;
      end
   end

   assign out_b = pipe_q[PIPE_LEN-1];
   assign tail = out_b.en && !pipe_q[TAIL_TAP].en;
   assign hdr_idx = (out_cnt_q < ADDR_LEN) ? out_cnt_q + ADDR_LEN
      : out_cnt_q - ADDR_LEN;

   always_comb begin
      sw_data = out_b.d;
      if (mode_s2_q.swap_en && out_cnt_q < HDR_LEN) begin
         sw_data = hdr_q[hdr_idx];
      end
      loop_b = out_b;
      loop_b.d = sw_data;
      if (mode_s2_q.swap_en && tail) begin
         loop_b.d = ~crc_q[{crc_idx_q, 3'b000} +: 8];
      end
   end

   // Delay line and header capture
   always_ff @(posedge LINK_CLK or posedge RESET) begin
      if (RESET) begin
         for (int i = 0; i < PIPE_LEN; i++) begin
            pipe_q[i] <= BYTE_IDLE;
            hdr_q[i] <= 8'h00;
         end
         in_cnt_q <= 4'h0;
      end else if (lce) begin
         pipe_q[0] <= LINE_RX;
         for (int i = 1; i < PIPE_LEN; i++) begin
            pipe_q[i] <= pipe_q[i-1];
         end
         if (!LINE_RX.en) begin
            in_cnt_q <= 4'h0;
         end else if (in_cnt_q < HDR_LEN) begin
            hdr_q[in_cnt_q] <= LINE_RX.d;
            in_cnt_q <= in_cnt_q + 4'h1;
         end
      end
   end

   // FCS regeneration
   always_ff @(posedge LINK_CLK or posedge RESET) begin
      if (RESET) begin
         out_cnt_q <= 4'h0;
         crc_idx_q <= 2'h0;
         crc_q <= CRC_INIT;
      end else if (lce) begin
         if (!out_b.en) begin
            out_cnt_q <= 4'h0;
            crc_q <= CRC_INIT;
         end else begin
            if (out_cnt_q < HDR_LEN) begin
               out_cnt_q <= out_cnt_q + 4'h1;
            end
            if (!tail) begin
               crc_q <= crc_byte(crc_q, sw_data);
            end
         end
         crc_idx_q <= tail ? crc_idx_q + 2'h1 : 2'h0;
      end
   end

   // Output steering
   assign frame_end = mode_s2_q.local_en ? (MAC_RX.en && !MAC_TX.en)
      : (mode_s2_q.remote_en && out_b.en && !pipe_q[PIPE_LEN-2].en);

   always_ff @(posedge LINK_CLK or posedge RESET) begin
      if (RESET) begin
         MAC_RX <= BYTE_IDLE;
         LINE_TX <= BYTE_IDLE;
         done_tgl_q <= 1'b0;
      end else if (lce) begin
         if (mode_s2_q.local_en) begin
            MAC_RX <= MAC_TX;
            LINE_TX <= BYTE_IDLE;
         end else if (mode_s2_q.remote_en) begin
            MAC_RX <= LINE_RX;
            LINE_TX <= loop_b;
         end else begin
            MAC_RX <= LINE_RX;
            LINE_TX <= MAC_TX;
         end
         if (frame_end) begin
            done_tgl_q <= !done_tgl_q;
         end
      end
   end

   // Checks
   property p_local_echo;
      @(posedge LINK_CLK) disable iff (RESET)
      (mode_s2_q.local_en && lce) |=> (MAC_RX == $past(MAC_TX));
   endproperty
   a_local_echo: assert property (p_local_echo)
      else $error("Local loop did not echo MAC byte");

   property p_loop_bit;
      @(posedge SYS_CLK) disable iff (RESET)
      (wr && PADDR[7:0] == ADDR_BASIC && !PWDATA[BC_LOOP])
      |=> !lb_mode.local_en;
   endproperty
   a_loop_bit: assert property (p_loop_bit)
      else $error("Local loop active with enable bit clear");

   property p_speed_status;
      @(posedge SYS_CLK) disable iff (RESET)
      (xfer && CE && !PWRITE && PADDR[7:0] == ADDR_STATUS)
      |-> (PRDATA[5:4] == {basic_q[BC_SPD_LSB], basic_q[BC_SPD_MSB]});
   endproperty
   a_speed_status: assert property (p_speed_status)
      else $error("Status speed code disagrees with control bits");

   property p_an_blocks;
      @(posedge SYS_CLK) disable iff (RESET)
      (basic_q[BC_AN_EN] || !basic_q[BC_DUPLEX]) |-> !lb_mode.local_en;
   endproperty
   a_an_blocks: assert property (p_an_blocks)
      else $error("Local loop with autoneg or half duplex");

   property p_gig_slave;
      @(posedge SYS_CLK) disable iff (RESET)
      (lb_mode.speed == SPD_1000 && ms_q[MS_VALUE]) |-> !lb_mode.local_en;
   endproperty
   a_gig_slave: assert property (p_gig_slave)
      else $error("Gigabit local loop while set as master");

   property p_remote_path;
      @(posedge LINK_CLK) disable iff (RESET)
      (lce && mode_s2_q.remote_en && !mode_s2_q.local_en
      && !mode_s2_q.swap_en) |=> (LINE_TX == $past(pipe_q[PIPE_LEN-1]));
   endproperty
   a_remote_path: assert property (p_remote_path)
      else $error("Remote loop byte not returned to line");

   property p_remote_gate;
      @(posedge SYS_CLK) disable iff (RESET)
      lb_mode.remote_en |-> (pcs_q[PCS_REMOTE]
      && (forced_gig || (basic_q[BC_AN_EN] && an_s2_q)));
   endproperty
   a_remote_gate: assert property (p_remote_gate)
      else $error("Remote loop without enable or gigabit link");

   sequence s_fcs_start;
      lce && mode_s2_q.swap_en && mode_s2_q.remote_en && tail
      && crc_idx_q == 2'h0;
   endsequence
   property p_fcs_first;
      @(posedge LINK_CLK) disable iff (RESET)
      s_fcs_start |=> (LINE_TX.en && LINE_TX.d == ~$past(crc_q[7:0]));
   endproperty
   a_fcs_first: assert property (p_fcs_first)
      else $error("First regenerated FCS byte wrong");

   property p_switch_bit;
      @(posedge SYS_CLK) disable iff (RESET)
      !common_q[CC_SWITCH_LB] |-> !lb_mode.swap_en;
   endproperty
   a_switch_bit: assert property (p_switch_bit)
      else $error("Switch mode active with its bit clear");

   property p_ext_path;
      @(posedge LINK_CLK) disable iff (RESET)
      (lce && mode_s2_q.ext_en) |=> (LINE_TX == $past(MAC_TX));
   endproperty
   a_ext_path: assert property (p_ext_path)
      else $error("Connector loop did not pass MAC data to line");

   property p_ext_gig;
      @(posedge SYS_CLK) disable iff (RESET)
      (lb_mode.ext_en && lb_mode.speed == SPD_1000)
      |-> (basic_q == EXT_GIG_BASIC && ms_q[MS_VALUE]);
   endproperty
   a_ext_gig: assert property (p_ext_gig)
      else $error("Gigabit connector loop without required setup");

   property p_no_leak;
      @(posedge LINK_CLK) disable iff (RESET)
      (lce && mode_s2_q.local_en && !MAC_TX.en) |=> !MAC_RX.en;
   endproperty
   a_no_leak: assert property (p_no_leak)
      else $error("Line data reached MAC during local loop");
endmodule
`default_nettype wire

// >>> common/plbk_pkg.sv
// Purpose: Constants and types for the loopback control block
// Assumes: 32-bit APB register access, byte-wide link data
// Notes: Offsets, bit positions and link carrier types
// Overview of operation
// - Near-end loop returns MAC frames, full-duplex
// - Basic control bit 14 enables local loop
// - Bits {6,13}: 10=1000, 00=10, 01=100
// - Bit 12 clear, bit 8 set for loop
// - Gigabit local loop needs manual slave setting
// - Far-end loop returns line frames, gigabit only
// - PCS loop control bit 8 enables remote loop
// - Switch mode swaps addresses, recomputes FCS
// - Common control bit enables switch mode
// - Connector loop at all speeds, gigabit needs basic 0x0140 and manual master
package plbk_pkg;
   localparam logic [7:0] ADDR_BASIC = 8'h00;
   localparam logic [7:0] ADDR_MS = 8'h04;
   localparam logic [7:0] ADDR_PCS_LB = 8'h08;
   localparam logic [7:0] ADDR_COMMON = 8'h0c;
   localparam logic [7:0] ADDR_EXT_LB = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_FRAMES = 8'h18;
   localparam int BC_SPD_LSB = 6;
   localparam int BC_DUPLEX = 8;
   localparam int BC_AN_EN = 12;
   localparam int BC_SPD_MSB = 13;
   localparam int BC_LOOP = 14;
   localparam int MS_VALUE = 11;
   localparam int MS_MANUAL = 12;
   localparam int PCS_REMOTE = 8;
   localparam int CC_SWITCH_LB = 0;
   localparam int EXT_LB_BIT = 0;
   localparam logic [15:0] BASIC_RST = 16'h1000;
   localparam logic [15:0] REG_ZERO_RST = 16'h0000;
   localparam logic [15:0] EXT_GIG_BASIC = 16'h0140;
   localparam logic [1:0] SPD_10 = 2'h0;
   localparam logic [1:0] SPD_100 = 2'h1;
   localparam logic [1:0] SPD_1000 = 2'h2;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam int PIPE_LEN = 12;
   localparam int MAC_LEN = 6;
   localparam int TAIL_TAP = 7;
   localparam logic [3:0] HDR_LEN = 4'hc;
   localparam logic [3:0] ADDR_LEN = 4'h6;
   typedef struct packed {
      logic en;
      logic er;
      logic [7:0] d;
   } plbk_byte_t;
   typedef struct packed {
      logic local_en;
      logic remote_en;
      logic swap_en;
      logic ext_en;
      logic [1:0] speed;
   } plbk_mode_t;
   localparam plbk_byte_t BYTE_IDLE = '0;
endpackage

// >>> bench/plbk_partner.sv
// Purpose: Far-side byte source for the MAC or line stream
// Assumes: One frame per go pulse, DA byte first, no preamble
// Notes: Idle data toggles so stale bytes never look valid
`timescale 1ns/1ps
`default_nettype none
module plbk_partner
   import plbk_pkg::*;
(
   input wire logic link_clk,
   input wire logic go,
   input wire logic [7:0] base,
   input wire logic [7:0] len,
   output var plbk_byte_t tx,
   output var logic busy
);
   logic [7:0] cnt_q = 8'h00;
   initial tx = BYTE_IDLE;
   initial busy = 1'b0;
   always @(posedge link_clk) begin
      if (go && !busy) begin
         busy <= 1'b1;
         cnt_q <= 8'h00;
      end else if (busy) begin
         cnt_q <= cnt_q + 8'h01;
      end
      tx.er <= 1'b0;
      tx.en <= busy && cnt_q < len;
      tx.d <= (busy && cnt_q < len) ? base + cnt_q : ~tx.d;
      if (busy && cnt_q == len + 8'h0b) begin
         busy <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> bench/phy_loopback_control_tb.sv
// Purpose: Self-checking bench for the loopback control block
// Assumes: CE held high, byte link on one free-running clock
// Notes: Modes set over APB, frames checked byte by byte
`timescale 1ns/1ps
`default_nettype none
module phy_loopback_control_tb
   import plbk_pkg::*;
   ;
   typedef logic [7:0] plbk_q_t[$];
   logic sys_clk = 1'b0, link_clk = 1'b0, reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, an = 1'b0;
   logic go_m = 1'b0, go_l = 1'b0, pready, pslverr, se, bm, bl;
   logic [7:0] paddr = 8'h00, len = 8'h10;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   plbk_byte_t mac_tx, mac_rx, line_rx, line_tx;
   plbk_q_t q_mac, q_line;
   int err_count = 0, tests_run = 0, k;
   logic [63:0] tbl [11] = '{
      64'h4100_0000_0000_0101, 64'h6100_0000_0000_1101,
      64'h5100_0000_0000_0000, 64'h4140_0000_0000_2000,
      64'h4140_1000_0000_2101, 64'h4140_1800_0000_2000,
      64'h6140_1000_0000_3000, 64'h0140_0000_0100_2202,
      64'h2100_0000_0100_1000, 64'h1000_0000_0100_0000,
      64'h1000_0000_0100_0212};

   always #20 sys_clk = ~sys_clk;
   always #16 link_clk = ~link_clk;

   plbk_core #(.ADDR_W(8)) uut (
      .SYS_CLK(sys_clk), .RESET(reset), .CE(1'b1), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .AN_GIG_FD(an), .LINK_CLK(link_clk),
      .MAC_TX(mac_tx), .MAC_RX(mac_rx), .LINE_RX(line_rx),
      .LINE_TX(line_tx));
   plbk_partner mac_side (.link_clk(link_clk), .go(go_m),
      .base(8'h10), .len(len), .tx(mac_tx), .busy(bm));
   plbk_partner line_side (.link_clk(link_clk), .go(go_l),
      .base(8'h80), .len(len), .tx(line_rx), .busy(bl));

   always @(negedge link_clk) begin
      if (mac_rx.en === 1'b1) q_mac.push_back(mac_rx.d);
      if (line_tx.en === 1'b1) q_line.push_back(line_tx.d);
   end

   task results;
      if (err_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) begin
            rd = prdata;
            se = pslverr;
            break;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         err_count++;
         results();
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   function automatic plbk_q_t frm(input logic [7:0] b, input int n,
                                   input bit sw);
      plbk_q_t q;
      logic [31:0] c;
      int j;
      for (int i = 0; i < n; i++) begin
         j = (!sw || i > 11) ? i : ((i < 6) ? i + 6 : i - 6);
         q.push_back(b + j[7:0]);
      end
      if (sw) begin
         c = 32'hffffffff;
         for (int i = 0; i < n - 4; i++) begin
            c = c ^ {24'h0, q[i]};
            repeat (8) begin
               c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
            end
         end
         c = ~c;
         for (int i = 0; i < 4; i++) begin
            q[n - 4 + i] = c[8 * i +: 8];
         end
      end
      return q;
   endfunction

   task cmpq(input plbk_q_t got, input plbk_q_t exp);
      chk(32'(got.size()), 32'(exp.size()));
      foreach (exp[i]) begin
         chk({24'h0, got[i]}, {24'h0, exp[i]});
      end
   endtask

   task run(input int kind);
      int n;
      q_mac.delete();
      q_line.delete();
      repeat (4) @(posedge link_clk);
      go_m <= kind != 2;
      go_l <= 1'b1;
      repeat (2) @(posedge link_clk);
      go_m <= 1'b0;
      go_l <= 1'b0;
      for (n = 0; n < 200; n++) begin
         @(posedge link_clk);
         if (!bm && !bl) break;
      end
      repeat (20) @(posedge link_clk);
      if (n == 200) begin
         err_count++;
         results();
      end
   endtask

   initial begin
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rdc(ADDR_BASIC, 32'h00001000);
      rdc(ADDR_STATUS, 32'h0);
      xfer(1'b0, 8'h1c, 32'h0);
      chk({31'h0, se}, 32'h1);
      chk(rd, 32'h0);
      foreach (tbl[i]) begin
         an <= tbl[i][4];
         wr(ADDR_BASIC, {16'h0, tbl[i][63:48]});
         wr(ADDR_MS, {16'h0, tbl[i][47:32]});
         wr(ADDR_PCS_LB, {16'h0, tbl[i][31:16]});
         rdc(ADDR_STATUS, {24'h0, tbl[i][15:8]});
         if (tbl[i][3:0] == 4'h1) begin
            run(1);
            cmpq(q_mac, frm(8'h10, 16, 1'b0));
            chk(32'(q_line.size()), 32'h0);
         end else if (tbl[i][3:0] == 4'h2) begin
            run(2);
            cmpq(q_line, frm(8'h80, 16, 1'b0));
         end
      end
      wr(ADDR_COMMON, 32'h1);
      rdc(ADDR_COMMON, 32'h1);
      for (k = 16; k <= 24; k += 8) begin
         len <= k[7:0];
         run(2);
         cmpq(q_line, frm(8'h80, k, 1'b1));
      end
      wr(ADDR_COMMON, 32'h0);
      wr(ADDR_PCS_LB, 32'h0);
      an <= 1'b0;
      wr(ADDR_BASIC, 32'h140);
      wr(ADDR_MS, 32'h1800);
      wr(ADDR_EXT_LB, 32'h1);
      rdc(ADDR_STATUS, 32'h28);
      run(3);
      cmpq(q_mac, frm(8'h80, 24, 1'b0));
      cmpq(q_line, frm(8'h10, 24, 1'b0));
      wr(ADDR_BASIC, 32'h2100);
      rdc(ADDR_STATUS, 32'h18);
      rdc(ADDR_FRAMES, 32'h7);
      results();
   end
endmodule
`default_nettype wire
